// file: dv/can_engine_model.sv
// far side: starts an offered frame, reports one outcome
// outcome 0 ok, 1 arbitration loss, 2 bus error, 3 never start
`timescale 1ns/1ns
`default_nettype none
module can_engine_model (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       tx_req,
    input wire logic [1:0] outcome,
    input wire logic [3:0] lag,
    output logic           tx_start,
    output logic           tx_ok,
    output logic           tx_arb_lost,
    output logic           tx_bus_err
);
    logic       active; // a frame is on the bus
    logic [3:0] cnt;    // cycles spent in the current phase
    // wait lag, start, wait lag, outcome
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {active, cnt, tx_start, tx_ok, tx_arb_lost, tx_bus_err} <= '0;
        end else begin
            {tx_start, tx_ok, tx_arb_lost, tx_bus_err} <= 4'h0;
            if (!active) begin
                // a withdrawn offer restarts the wait
                cnt <= (tx_req && outcome != 2'h3 && cnt != lag) ? cnt + 4'h1 : 4'h0;
                active <= tx_req && outcome != 2'h3 && cnt == lag;
                tx_start <= tx_req && outcome != 2'h3 && cnt == lag;
            end else if (cnt == lag) begin
                active <= 1'b0;
                cnt <= 4'h0;
                tx_ok <= outcome == 2'h0;
                tx_arb_lost <= outcome == 2'h1;
                tx_bus_err <= outcome == 2'h2;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/mbx_chk.sv
// checker: handshake, offer release, event causes
// assumes binding to the mailbox top, ports only
`timescale 1ns/1ns
`default_nettype none
module mbx_chk (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tx_req,
    input wire logic        tx_start,
    input wire logic        tx_ok,
    input wire logic        tx_arb_lost,
    input wire logic        tx_bus_err,
    input wire logic        rx_valid,
    input wire logic        tx_done_event,
    input wire logic        overrun_event
);
    // one clock domain, quiet in reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // unmapped global address
    wire logic hole = avs_address[9] && avs_address != 10'h200 && avs_address != 10'h204;
    a_wait_answer: assert property (($rose(avs_read) || $rose(avs_write)) |=> !avs_waitrequest)
        else $error("no answer");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    a_hole_reads_zero: assert property ($rose(avs_read) && hole |=> avs_readdata == 32'h0)
        else $error("hole not zero");
    a_start_drops_offer: assert property (tx_start && tx_req |=> !tx_req)
        else $error("offer kept");
    a_fail_no_event: assert property ((tx_arb_lost || tx_bus_err) && !tx_ok |=> !tx_done_event)
        else $error("event on failure");
    a_event_has_ok: assert property (tx_done_event |-> $past(tx_ok))
        else $error("event without ok");
    a_event_single: assert property (tx_done_event |=> !tx_done_event)
        else $error("long event");
    a_overrun_cause: assert property (overrun_event |-> $past(rx_valid))
        else $error("overrun without frame");
endmodule
bind can_mailbox_abort_and_receive mbx_chk chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_req(tx_req), .tx_start(tx_start), .tx_ok(tx_ok), .tx_arb_lost(tx_arb_lost),
    .tx_bus_err(tx_bus_err), .rx_valid(rx_valid), .tx_done_event(tx_done_event),
    .overrun_event(overrun_event));
`default_nettype wire

// file: dv/test_can_mailbox_abort_and_receive.sv
// bench: one task per scenario
// assumes package, design, model and checker compiled
`timescale 1ns/1ns
`default_nettype none
module test_can_mailbox_abort_and_receive;
    logic        core_clk, sys_rst, avs_read, avs_write, avs_waitrequest, rx_valid, rx_rtr;
    logic        tx_req, tx_ide, tx_rtr, tx_start, tx_ok, tx_arb_lost, tx_bus_err;
    logic        tx_done_event, overrun_event;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [4:0]  tx_mb;
    logic [28:0] tx_id, rx_id;
    logic [3:0]  tx_dlc, lag;
    logic [63:0] tx_data, rx_data;
    logic [1:0]  outcome;
    int          miscompares, samples_checked, i;
    can_mailbox_abort_and_receive dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_req(tx_req),
        .tx_mb(tx_mb), .tx_id(tx_id), .tx_ide(tx_ide), .tx_rtr(tx_rtr), .tx_dlc(tx_dlc),
        .tx_data(tx_data), .tx_start(tx_start), .tx_ok(tx_ok), .tx_arb_lost(tx_arb_lost),
        .tx_bus_err(tx_bus_err), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(1'b0),
        .rx_rtr(rx_rtr), .rx_dlc(4'h0), .rx_data(rx_data),
        .tx_done_event(tx_done_event), .overrun_event(overrun_event));
    can_engine_model eng (
        .core_clk(core_clk), .sys_rst(sys_rst), .tx_req(tx_req), .outcome(outcome),
        .lag(lag), .tx_start(tx_start), .tx_ok(tx_ok), .tx_arb_lost(tx_arb_lost),
        .tx_bus_err(tx_bus_err));
    // single comparison point
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one transfer, held until waitrequest low
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input string what, input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask
    // word w of mailbox j
    function automatic logic [9:0] mb(input int j, input int w);
        return 10'(j * 16 + w * 4);
    endfunction
    // one frame, then lines flip
    task automatic rx(input logic [28:0] id, input logic rtr, input logic [63:0] d);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_rtr <= rtr;
        rx_data <= d;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_id <= ~id;
        rx_data <= ~d;
        @(posedge core_clk);
    endtask
    // pulses of an event in 30 cycles
    task automatic pulses(input string what, ref logic ev, input int exp);
        int n;
        n = 0;
        repeat (30) begin
            @(posedge core_clk);
            n += (ev === 1'b1);
        end
        chk(what, exp, n);
    endtask
    task automatic t_reset;
        rd("ctrl0", mb(0, 0), 32'h0);
        rd("mask", 10'h204, 32'h1fffffff);
        rd("unmapped", 10'h208, 32'h0);
        wr(mb(31, 1), 32'h0000_0abc);
        rd("id31", mb(31, 1), 32'h0000_0abc);
    endtask
    // normal send: lost, retried, sent
    task automatic t_tx_normal;
        wr(10'h200, 32'h4);
        outcome <= 2'h1;
        wr(mb(3, 0), 32'h100);
        pulses("lost event", tx_done_event, 0);
        outcome <= 2'h0;
        pulses("sent event", tx_done_event, 1);
        rd("sent", mb(3, 0), 32'h102);
    endtask
    // single attempt dropped on loss, error
    task automatic t_tx_single;
        for (i = 1; i < 3; i++) begin
            outcome <= 2'(i);
            wr(mb(4, 0), 32'h140);
            pulses("single event", tx_done_event, 0);
            rd("single fail", mb(4, 0), 32'h048);
            wr(mb(4, 0), 32'h0);
        end
    endtask
    // abort idle, on lost and won frames
    task automatic t_abort;
        outcome <= 2'h3;
        wr(mb(5, 0), 32'h100);
        wr(mb(5, 0), 32'h00f);
        rd("abort idle", mb(5, 0), 32'h008);
        lag <= 4'ha;
        for (i = 0; i < 2; i++) begin
            outcome <= 2'(1 - i);
            wr(mb(6 + i, 0), 32'h100);
            for (int n = 0; n < 40 && tx_start !== 1'b1; n++) @(posedge core_clk);
            chk("offer", 6 + i, tx_mb);
            wr(mb(6 + i, 0), 32'h00f);
            repeat (30) @(posedge core_clk);
            rd("abort bus", mb(6 + i, 0), i ? 32'h002 : 32'h008);
        end
    endtask
    // lowest, remote, overwrite, keep, overrun
    task automatic t_rx_normal;
        wr(mb(8, 1), 32'h123);
        wr(mb(9, 1), 32'h123);
        wr(mb(8, 0), 32'h080);
        wr(mb(9, 0), 32'h080);
        rx(29'h123, 1'b1, 64'h1111);
        rd("low store", mb(8, 0), 32'h081);
        rd("high idle", mb(9, 0), 32'h080);
        rd("remote id", mb(8, 1), 32'h4000_0123);
        rx(29'h123, 1'b0, 64'h2222);
        rd("overwrite", mb(8, 0), 32'h085);
        rd("new data", mb(8, 2), 32'h2222);
        wr(mb(8, 0), 32'h08d);
        rd("ones keep", mb(8, 0), 32'h085);
        wr(10'h200, 32'h3);
        wr(mb(8, 0), 32'h080);
        rx(29'h123, 1'b0, 64'h3333);
        fork
            rx(29'h123, 1'b0, 64'h4444);
            pulses("overrun event", overrun_event, 1);
        join
        rd("overrun", mb(8, 0), 32'h085);
        rd("kept data", mb(8, 2), 32'h3333);
    endtask
    // single receivers fill, refuse, abort
    task automatic t_rx_single;
        wr(mb(10, 1), 32'h55);
        wr(mb(11, 1), 32'h55);
        wr(mb(10, 0), 32'h0c0);
        wr(mb(11, 0), 32'h0c0);
        rx(29'h55, 1'b0, 64'ha);
        rx(29'h55, 1'b0, 64'hb);
        rx(29'h55, 1'b0, 64'hc);
        rd("first", mb(10, 2), 32'ha);
        rd("second", mb(11, 2), 32'hb);
        wr(mb(10, 0), 32'h048);
        rx(29'h55, 1'b0, 64'hd);
        rd("rx abort", mb(10, 0), 32'h040);
        rd("full", mb(11, 0), 32'h0c1);
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 44'h0};
        {rx_valid, rx_rtr, rx_id, rx_data, lag, outcome} = {95'h0, 4'h2, 2'h3};
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_reset;
        t_tx_normal;
        t_tx_single;
        t_abort;
        t_rx_normal;
        t_rx_single;
        tally_and_finish;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        tally_and_finish;
    end
endmodule
`default_nettype wire

// file: rtl/can_mailbox_abort_and_receive.sv
// mailbox array: flags, abort, receive storage, bus slave
// assumes a core_clk engine giving start and outcome pulses
`timescale 1ns/1ns
`default_nettype none
module can_mailbox_abort_and_receive (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // transmit side
    output logic             tx_req,
    output logic [4:0]       tx_mb,
    output logic [28:0]      tx_id,
    output logic             tx_ide,
    output logic             tx_rtr,
    output logic [3:0]       tx_dlc,
    output logic [63:0]      tx_data,
    input  wire logic        tx_start,
    input  wire logic        tx_ok,
    input  wire logic        tx_arb_lost,
    input  wire logic        tx_bus_err,
    // receive side
    input  wire logic        rx_valid,
    input  wire logic [28:0] rx_id,
    input  wire logic        rx_ide,
    input  wire logic        rx_rtr,
    input  wire logic [3:0]  rx_dlc,
    input  wire logic [63:0] rx_data,
    // event pulses
    output logic             tx_done_event,
    output logic             overrun_event
);
    localparam int N = mbx_pkg::NUM_MB;

    // per-mailbox control bits
    logic [N-1:0] new_data_flag;     // reception complete
    logic [N-1:0] sent_flag;         // transmission complete
    logic [N-1:0] message_lost_flag; // overwrite or overrun happened
    logic [N-1:0] abort_done_flag;   // transmission abort complete
    logic [N-1:0] single_attempt_bit;
    logic [N-1:0] receive_set_bit;
    logic [N-1:0] transmit_set_bit;
    logic [N-1:0] abort_pend_reg;    // abort asked while on the bus
    logic [3:0]   dlc_mem  [N];      // length code
    logic [31:0]  id_mem   [N];      // identifier word
    logic [31:0]  dlo_mem  [N];      // data low word
    logic [31:0]  dhi_mem  [N];      // data high word
    logic [2:0]   gctrl_reg;         // policy and event enables
    logic [28:0]  mask_reg;          // acceptance mask, 1 = compare
    logic         active_reg;        // a mailbox is on the bus
    logic [4:0]   active_mb_reg;     // which one
    logic         ack_reg;           // bus answer cycle

    // bus decode
    logic         wr_commit;         // write takes effect this edge
    logic         is_mb;             // address hits a mailbox word
    logic [4:0]   sel_mb;
    logic [1:0]   sel_word;
    assign wr_commit = avs_write & ack_reg;
    assign is_mb     = ~avs_address[mbx_pkg::GLOBAL_BIT];
    assign sel_mb    = avs_address[mbx_pkg::MB_SEL_LSB +: mbx_pkg::MB_IDX_W];
    assign sel_word  = avs_address[3:2];

    // outcome of the active frame
    logic         tx_fail;
    logic         out_ok;
    logic         out_fail;
    assign tx_fail  = tx_arb_lost | tx_bus_err;
    assign out_ok   = active_reg & tx_ok;
    assign out_fail = active_reg & tx_fail & ~tx_ok;

    // acceptance and lowest-number search
    logic [N-1:0] rx_match;          // identifier matches after mask
    logic [N-1:0] rx_cand;           // match that may take the frame
    logic         rx_found;
    logic [4:0]   rx_sel;
    logic         rx_store;          // frame is written into rx_sel
    logic         rx_overrun;        // frame discarded, lost flag set
    always_comb begin
        rx_found = 1'b0;
        rx_sel   = 5'h00;
        for (int j = 0; j < N; j++) begin
            // data and remote frames both accepted
            rx_match[j] = receive_set_bit[j] & ~transmit_set_bit[j]
                        & (id_mem[j][mbx_pkg::IDW_IDE] == rx_ide)
                        & (((id_mem[j][28:0] ^ rx_id) & mask_reg) == 29'h0000000);
            // full single-attempt receiver stands aside
            rx_cand[j]  = rx_match[j] & ~(single_attempt_bit[j] & new_data_flag[j]);
        end
        // scan downward so the lowest number wins
        for (int j = N - 1; j >= 0; j--) begin
            if (rx_cand[j]) begin
                rx_found = 1'b1;
                rx_sel   = j[4:0];
            end
        end
    end
    // overrun: normal receiver still unread under the overrun policy
    assign rx_overrun = rx_valid & rx_found & new_data_flag[rx_sel]
                      & gctrl_reg[mbx_pkg::GC_POLICY];
    assign rx_store   = rx_valid & rx_found & ~rx_overrun;

    // transmit choice: lowest pending mailbox
    logic [N-1:0] tx_elig;
    logic         tx_any;
    logic [4:0]   tx_pick;
    always_comb begin
        tx_any  = 1'b0;
        tx_pick = 5'h00;
        for (int j = N - 1; j >= 0; j--) begin
            tx_elig[j] = transmit_set_bit[j] & ~receive_set_bit[j]
                       & ~sent_flag[j] & ~abort_pend_reg[j];
            if (tx_elig[j]) begin
                tx_any  = 1'b1;
                tx_pick = j[4:0];
            end
        end
    end

    // control flags: software first, hardware set wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            new_data_flag      <= '0;
            sent_flag          <= '0;
            message_lost_flag  <= '0;
            abort_done_flag    <= '0;
            single_attempt_bit <= '0;
            receive_set_bit    <= '0;
            transmit_set_bit   <= '0;
            abort_pend_reg     <= '0;
        end else begin
            for (int j = 0; j < N; j++) begin
                // software write of a control word
                if (wr_commit && is_mb && sel_mb == j[4:0] && sel_word == mbx_pkg::WORD_CTRL) begin
                    // flags only clear by writing zero
                    new_data_flag[j]     <= new_data_flag[j]
                                          & avs_writedata[mbx_pkg::CTL_NEW_DATA];
                    sent_flag[j]         <= sent_flag[j] & avs_writedata[mbx_pkg::CTL_SENT];
                    message_lost_flag[j] <= message_lost_flag[j]
                                          & avs_writedata[mbx_pkg::CTL_LOST];
                    abort_done_flag[j]   <= abort_done_flag[j]
                                          & avs_writedata[mbx_pkg::CTL_ABORT_DONE];
                    single_attempt_bit[j]<= avs_writedata[mbx_pkg::CTL_SINGLE];
                    // clearing receive with both flags drops reception
                    receive_set_bit[j]   <= avs_writedata[mbx_pkg::CTL_RX_SET];
                    if (avs_writedata[mbx_pkg::CTL_TX_SET]) begin
                        transmit_set_bit[j] <= 1'b1;
                    end else if (transmit_set_bit[j] && !sent_flag[j]) begin
                        // abort request on a pending message
                        transmit_set_bit[j] <= 1'b0;
                        if (active_reg && active_mb_reg == j[4:0]) begin
                            abort_pend_reg[j] <= 1'b1;         // wait for bus outcome
                        end else begin
                            abort_done_flag[j] <= 1'b1;
                        end
                    end else begin
                        transmit_set_bit[j] <= 1'b0;
                    end
                end
                // transmit outcome on the active mailbox
                if (active_mb_reg == j[4:0]) begin
                    if (out_ok) begin
                        sent_flag[j]      <= 1'b1;
                        abort_pend_reg[j] <= 1'b0;
                    end else if (out_fail) begin
                        if (abort_pend_reg[j]) begin
                            abort_done_flag[j] <= 1'b1;
                            abort_pend_reg[j]  <= 1'b0;
                        end else if (single_attempt_bit[j]) begin
                            // drop the message instead of retrying
                            abort_done_flag[j]  <= 1'b1;
                            transmit_set_bit[j] <= 1'b0;
                        end
                    end
                end
                // reception outcome on the chosen mailbox
                if (rx_sel == j[4:0]) begin
                    if (rx_store) begin
                        new_data_flag[j] <= 1'b1;
                        if (new_data_flag[j]) begin
                            message_lost_flag[j] <= 1'b1;
                        end
                    end else if (rx_overrun) begin
                        message_lost_flag[j] <= 1'b1;
                    end
                end
            end
        end
    end

    // storage: a stored frame wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int j = 0; j < N; j++) begin
                dlc_mem[j] <= 4'h0;
                id_mem[j]  <= 32'h00000000;
                dlo_mem[j] <= 32'h00000000;
                dhi_mem[j] <= 32'h00000000;
            end
        end else begin
            if (wr_commit && is_mb) begin
                case (sel_word)
                    mbx_pkg::WORD_CTRL: begin
                        dlc_mem[sel_mb] <= avs_writedata[mbx_pkg::CTL_DLC_LSB +: mbx_pkg::DLC_W];
                    end
                    mbx_pkg::WORD_ID: begin
                        id_mem[sel_mb] <= avs_writedata;
                    end
                    mbx_pkg::WORD_DATA_LO: begin
                        dlo_mem[sel_mb] <= avs_writedata;
                    end
                    default: begin
                        dhi_mem[sel_mb] <= avs_writedata;
                    end
                endcase
            end
            if (rx_store) begin
                // frame replaces old content
                dlc_mem[rx_sel] <= rx_dlc;
                id_mem[rx_sel]  <= {rx_ide, rx_rtr, 1'b0, rx_id};
                dlo_mem[rx_sel] <= rx_data[31:0];
                dhi_mem[rx_sel] <= rx_data[63:32];
            end
        end
    end

    // global control and mask registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gctrl_reg <= 3'h0;
            mask_reg  <= mbx_pkg::MASK_RESET;
        end else if (wr_commit && !is_mb) begin
            if (avs_address == mbx_pkg::GLOBAL_CTRL_ADDR) begin
                gctrl_reg <= avs_writedata[2:0];
            end else if (avs_address == mbx_pkg::MASK_ADDR) begin
                mask_reg <= avs_writedata[28:0];
            end
        end
    end

    // active transmission tracking
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_reg    <= 1'b0;
            active_mb_reg <= 5'h00;
        end else if (out_ok || out_fail) begin
            active_reg <= 1'b0;
        end else if (tx_start && tx_req && !active_reg) begin
            active_reg    <= 1'b1;
            active_mb_reg <= tx_mb;
        end
    end

    // transmit offer, withdrawn while a frame is active
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_req  <= 1'b0;
            tx_mb   <= 5'h00;
            tx_id   <= 29'h0000000;
            tx_ide  <= 1'b0;
            tx_rtr  <= 1'b0;
            tx_dlc  <= 4'h0;
            tx_data <= 64'h0;
        end else begin
            tx_req  <= tx_any & ~active_reg & ~(tx_start & tx_req);
            tx_mb   <= tx_pick;
            tx_id   <= id_mem[tx_pick][28:0];
            tx_ide  <= id_mem[tx_pick][mbx_pkg::IDW_IDE];
            tx_rtr  <= id_mem[tx_pick][mbx_pkg::IDW_RTR];
            tx_dlc  <= dlc_mem[tx_pick];
            tx_data <= {dhi_mem[tx_pick], dlo_mem[tx_pick]};
        end
    end

    // events: only success reports completion
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_done_event <= 1'b0;
            overrun_event <= 1'b0;
        end else begin
            tx_done_event <= out_ok & gctrl_reg[mbx_pkg::GC_TXDONE_EN];
            overrun_event <= rx_overrun & gctrl_reg[mbx_pkg::GC_OVR_EN];
        end
    end

    // read value of the addressed register
    logic [31:0]  rd_value;
    always_comb begin
        rd_value = 32'h00000000;
        if (is_mb) begin
            if (sel_word == mbx_pkg::WORD_CTRL) begin
                rd_value[mbx_pkg::CTL_NEW_DATA]   = new_data_flag[sel_mb];
                rd_value[mbx_pkg::CTL_SENT]       = sent_flag[sel_mb];
                rd_value[mbx_pkg::CTL_LOST]       = message_lost_flag[sel_mb];
                rd_value[mbx_pkg::CTL_ABORT_DONE] = abort_done_flag[sel_mb];
                rd_value[mbx_pkg::CTL_TX_ACTIVE]  = active_reg & (active_mb_reg == sel_mb);
                rd_value[mbx_pkg::CTL_ABORT_PEND] = abort_pend_reg[sel_mb];
                rd_value[mbx_pkg::CTL_SINGLE]     = single_attempt_bit[sel_mb];
                rd_value[mbx_pkg::CTL_RX_SET]     = receive_set_bit[sel_mb];
                rd_value[mbx_pkg::CTL_TX_SET]     = transmit_set_bit[sel_mb];
                rd_value[mbx_pkg::CTL_DLC_LSB +: mbx_pkg::DLC_W] = dlc_mem[sel_mb];
            end else if (sel_word == mbx_pkg::WORD_ID) begin
                rd_value = id_mem[sel_mb];
            end else if (sel_word == mbx_pkg::WORD_DATA_LO) begin
                rd_value = dlo_mem[sel_mb];
            end else begin
                rd_value = dhi_mem[sel_mb];
            end
        end else if (avs_address == mbx_pkg::GLOBAL_CTRL_ADDR) begin
            rd_value = {29'h0000000, gctrl_reg};
        end else if (avs_address == mbx_pkg::MASK_ADDR) begin
            rd_value = {3'h0, mask_reg};
        end
    end

    // handshake: one wait cycle, one answer cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg         <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            if ((avs_read || avs_write) && !ack_reg) begin
                ack_reg         <= 1'b1;
                avs_waitrequest <= 1'b0;
                avs_readdata    <= rd_value;
            end else begin
                ack_reg         <= 1'b0;
                avs_waitrequest <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/mbx_pkg.sv
// mailbox package: register map, bit positions, widths
// assumes a 32-bit avalon-mm slave port and a same-clock protocol engine
// Behaviour
// - no completion event for failed single-attempt sends
// - single-attempt drops on loss, normal retries
// - abort drops pending message, reports via flags
// - successful send sets sent flag
// - abort before start sets abort-done flag
// - abort during send: loss/error sets abort-done
// - single-attempt transmit loss/error sets abort-done
// - success despite abort: sent, not abort-done
// - thirty-two mailboxes, each transmit or receive
// - frame goes to lowest matching mailbox
// - normal receive takes data and remote frames
// - single-attempt receivers fill upward while unprocessed
// - overwrite policy replaces unprocessed normal message
// - overwrite sets new data; lost if already new
// - overrun policy discards, sets lost, raises event
// - full single-attempt receiver refuses until cleared
// - clearing receive, new, lost together aborts reception
package mbx_pkg;
    localparam int          NUM_MB        = 32;       // mailboxes per channel
    localparam int          MB_IDX_W      = 5;        // mailbox index width
    localparam int          ADDR_W        = 10;       // byte address width
    localparam int          ID_W          = 29;       // identifier width
    localparam int          DLC_W         = 4;        // length code width
    // mailbox j at byte j*16
    localparam int          MB_SEL_LSB    = 4;        // mailbox number position
    localparam logic [1:0]  WORD_CTRL     = 2'h0;     // control word
    localparam logic [1:0]  WORD_ID       = 2'h1;     // identifier word
    localparam logic [1:0]  WORD_DATA_LO  = 2'h2;     // data bytes 0..3
    localparam logic [1:0]  WORD_DATA_HI  = 2'h3;     // data bytes 4..7
    localparam logic [ADDR_W-1:0] GLOBAL_CTRL_ADDR = 10'h200; // policy and event enables
    localparam logic [ADDR_W-1:0] MASK_ADDR        = 10'h204; // acceptance mask
    localparam int          GLOBAL_BIT    = 9;        // address bit marking globals
    // control word bits
    localparam int          CTL_NEW_DATA  = 0;
    localparam int          CTL_SENT      = 1;
    localparam int          CTL_LOST      = 2;
    localparam int          CTL_ABORT_DONE= 3;
    localparam int          CTL_TX_ACTIVE = 4;        // read only
    localparam int          CTL_ABORT_PEND= 5;        // read only
    localparam int          CTL_SINGLE    = 6;
    localparam int          CTL_RX_SET    = 7;
    localparam int          CTL_TX_SET    = 8;
    localparam int          CTL_DLC_LSB   = 12;
    // identifier word bits
    localparam int          IDW_RTR       = 30;
    localparam int          IDW_IDE       = 31;
    // global control bits
    localparam int          GC_POLICY     = 0;        // lost_policy_select: 0 overwrite, 1 overrun
    localparam int          GC_OVR_EN     = 1;        // overrun event enable
    localparam int          GC_TXDONE_EN  = 2;        // transmit-complete event enable
    // reset values
    localparam logic [ID_W-1:0] MASK_RESET = 29'h1fffffff; // exact compare
endpackage
